// file: pslp_pkg.sv
/*
 * Constants for the parallel slave port: register indices, bit positions,
 * reset values, the core phase codes and the completion stage type.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package pslp_pkg;
    // APB address width; each register index sits at byte address index * 4
    localparam int unsigned AW = 12;
    // Register indices
    localparam logic [7:0] IDX_DATA = 8'h08;
    localparam logic [7:0] IDX_CPINS = 8'h09;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_PIR = 8'h0C;
    localparam logic [7:0] IDX_DATA_PORT_DIRECTION = 8'h88;
    localparam logic [7:0] IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS = 8'h89;
    localparam logic [7:0] IDX_PIE = 8'h8C;
    localparam logic [7:0] IDX_ADCON = 8'h9F;
    // Field positions in the direction-and-status register
    localparam int unsigned B_IBF = 7;
    localparam int unsigned B_OBF = 6;
    localparam int unsigned B_INPUT_OVERFLOW_FLAG = 5;
    localparam int unsigned B_MODE = 4;
    // Port flag and enable position in the interrupt registers
    localparam int unsigned B_PIF = 7;
    // Reset values
    localparam logic [2:0] RST_DIR = 3'h7;
    localparam logic [7:0] RST_DATA_PORT_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [2:0] RST_ANALOG_PIN_CONFIG_FIELD = 3'h0;
    localparam logic [2:0] RST_STROBES = 3'h7;
    // Analog field value that makes the control pins digital
    localparam logic [2:0] ANALOG_PIN_CONFIG_FIELD_DIGITAL = 3'h7;
    // Core phase codes, Q1..Q4 as 0..3
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;
    // Completion stage after a strobe releases, Gray coded
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WAIT_Q2 = 2'b01,
        ST_WAIT_Q4 = 2'b11
    } pslp_stage_e;
endpackage

`default_nettype wire

// file: pslp_core.sv
/*
 * Parallel slave port with its APB register file.
 * Assumes pclk at 40 MHz, active-low asynchronous presetn, an APB master,
 * and an external processor driving active-low select, write and read
 * strobes asynchronously to pclk.
 */
// Implementation choice: the APB register port.
// Notes on behaviour
// - Slave mode lets outsider read/write data
// - Control pins become read, write, select strobes
// - Strobes need input direction and digital pins
// - Two latches share one data address
// - Slave mode ignores data direction register
// - Write starts when select and write low
// - Write end sets full and interrupt flags
// - In slave mode only CPU data read clears full flag
// - Write onto unread byte sets overflow
// - Read start clears output-full flag at once
// - Read end sets interrupt flag
// - Output-full stays low until firmware writes
// - Outside slave mode both full flags clear
// - Overflow cleared only by software write
// - Interrupt flag latched, gated by enable
// - Direction bits: one input, zero output
// - Slave-mode pins use TTL input thresholds
`default_nettype none

module pslp_core
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pslp_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic [7:0] data_pin_oe,
    input wire logic [2:0] ctl_pin_in,
    output logic [2:0] ctl_pin_out,
    output logic [2:0] ctl_pin_oe,
    output logic irq
);
    import pslp_pkg::*;

    // Address decode shared by the read mux and the write paths
    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction

    logic [1:0] phase_q; // Q1..Q4 phase of the core clock
    logic [2:0] ctl_s1_q; // First sync stage, read only by the second
    logic [2:0] ctl_s2_q; // Synchronised strobes
    logic [7:0] dat_s1_q; // First sync stage of the data pins
    logic [7:0] dat_s2_q; // Synchronised data pins
    logic [7:0] dout_q; // Outgoing latch
    logic [7:0] din_q; // Incoming latch
    logic [2:0] cpo_q; // Control pin output latch
    logic [7:0] interrupt_control_q; // Core interrupt control, plain storage
    logic pif_q; // Port interrupt flag
    logic pie_q; // Port interrupt enable
    logic [7:0] data_port_direction_q; // Data port direction
    logic mode_q; // Slave mode select
    logic [2:0] dir_q; // Control pin directions
    logic ibf_q; // Input full
    logic obf_q; // Output full
    logic input_overflow_flag_q; // Input overflow
    logic [2:0] analog_pin_config_field_q; // Analog pin configuration field
    logic [1:0] act_q; // Previous transfer activity, 0 write, 1 read
    logic [7:0] oe_q; // Data pin enables
    logic [31:0] prdata_q; // Registered read data
    logic digital; // Control pins configured digital
    logic [2:0] ctl_eff; // Strobes as seen by the port
    logic [1:0] act; // Transfer active now
    logic [1:0] ends; // Strobe release seen this cycle
    logic [1:0] starts; // Strobe assertion seen this cycle
    logic [1:0] fire; // Completion moment on Q4
    logic acc; // APB access phase
    logic wr_acc; // APB write access
    logic rd_acc; // APB read access
    logic mapped; // Address hits a register
    logic cpu_rd_data; // CPU reads the incoming latch
    logic cpu_wr_data; // CPU writes the outgoing latch
    logic [7:0] rd_val; // Read mux output

    // Free-running four-phase sequence derived from pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end

    // Two-flop synchronisers; thresholds are a pad matter, not logic here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_s1_q <= RST_STROBES;
            ctl_s2_q <= RST_STROBES;
            dat_s1_q <= 8'h00;
            dat_s2_q <= 8'h00;
        end
        else
        begin
            ctl_s1_q <= ctl_pin_in;
            ctl_s2_q <= ctl_s1_q;
            dat_s1_q <= data_pin_in;
            dat_s2_q <= dat_s1_q;
        end
    end

    // A pin left as output or analog can never act as a strobe
    assign digital = (analog_pin_config_field_q == ANALOG_PIN_CONFIG_FIELD_DIGITAL);
    assign ctl_eff = digital ? (ctl_s2_q | ~dir_q) : RST_STROBES;
    // Bit 2 select, bit 1 write, bit 0 read
    assign act[0] = mode_q & ~ctl_eff[2] & ~ctl_eff[1];
    assign act[1] = mode_q & ~ctl_eff[2] & ~ctl_eff[0];
    assign ends = act_q & ~act;
    assign starts = act & ~act_q;

    // Activity history for level-change detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            act_q <= 2'h0;
        else
            act_q <= act;
    end

    // Completion timing: wait for the next Q2, then flag on the Q4 after it
    for (genvar i = 0; i < 2; i++)
    begin : g_done
        pslp_stage_e st_q;
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                st_q <= ST_IDLE;
            else
            begin
                unique case (st_q)
                    ST_IDLE:
                    begin
                        // A release arms the completion sequence
                        if (ends[i])
                            st_q <= ST_WAIT_Q2;
                    end
                    ST_WAIT_Q2:
                    begin
                        if (phase_q == PH_Q2)
                            st_q <= ST_WAIT_Q4;
                    end
                    ST_WAIT_Q4:
                    begin
                        if (phase_q == PH_Q4)
                            st_q <= ST_IDLE;
                    end
                    default:
                    begin
                        // Unused code recovers to idle
                        st_q <= ST_IDLE;
                    end
                endcase
            end
        end
        assign fire[i] = (st_q == ST_WAIT_Q4) && (phase_q == PH_Q4);
    end

    // APB decode; the slave never inserts wait states
    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign mapped = hit(paddr, IDX_DATA) | hit(paddr, IDX_CPINS) | hit(paddr, IDX_INTERRUPT_CONTROL)
        | hit(paddr, IDX_PIR) | hit(paddr, IDX_DATA_PORT_DIRECTION) | hit(paddr, IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS)
        | hit(paddr, IDX_PIE) | hit(paddr, IDX_ADCON);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign cpu_rd_data = rd_acc & hit(paddr, IDX_DATA) & mode_q;
    assign cpu_wr_data = wr_acc & hit(paddr, IDX_DATA);

    // Read mux; unmapped and reserved bits read zero
    always_comb
    begin
        rd_val = 8'h00;
        if (hit(paddr, IDX_DATA))
            rd_val = mode_q ? din_q : data_pin_in;
        else if (hit(paddr, IDX_CPINS))
            rd_val = {5'h00, digital ? ctl_pin_in : 3'h0};
        else if (hit(paddr, IDX_INTERRUPT_CONTROL))
            rd_val = interrupt_control_q;
        else if (hit(paddr, IDX_PIR))
            rd_val = {pif_q, 7'h00};
        else if (hit(paddr, IDX_DATA_PORT_DIRECTION))
            rd_val = data_port_direction_q;
        else if (hit(paddr, IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS))
            rd_val = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0, dir_q};
        else if (hit(paddr, IDX_PIE))
            rd_val = {pie_q, 7'h00};
        else if (hit(paddr, IDX_ADCON))
            rd_val = {5'h00, analog_pin_config_field_q};
    end

    // Read data captured in the setup phase so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_q <= {24'h00_0000, rd_val};
    end
    assign prdata = prdata_q;

    // Plain software-owned configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dout_q <= 8'h00;
            cpo_q <= 3'h0;
            interrupt_control_q <= RST_INTERRUPT_CONTROL;
            pie_q <= 1'b0;
            data_port_direction_q <= RST_DATA_PORT_DIRECTION;
            mode_q <= 1'b0;
            dir_q <= RST_DIR;
            analog_pin_config_field_q <= RST_ANALOG_PIN_CONFIG_FIELD;
        end
        else if (wr_acc)
        begin
            if (hit(paddr, IDX_DATA))
                dout_q <= pwdata[7:0];
            if (hit(paddr, IDX_CPINS))
                cpo_q <= pwdata[2:0];
            if (hit(paddr, IDX_INTERRUPT_CONTROL))
                interrupt_control_q <= pwdata[7:0];
            if (hit(paddr, IDX_PIE))
                pie_q <= pwdata[B_PIF];
            if (hit(paddr, IDX_DATA_PORT_DIRECTION))
                data_port_direction_q <= pwdata[7:0];
            if (hit(paddr, IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS))
            begin
                mode_q <= pwdata[B_MODE];
                dir_q <= pwdata[2:0];
            end
            if (hit(paddr, IDX_ADCON))
                analog_pin_config_field_q <= pwdata[2:0];
        end
    end

    // Incoming latch follows the bus for the whole write strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            din_q <= 8'h00;
        else if (act[0])
            din_q <= dat_s2_q;
    end

    // Input full: completion sets, and wins over a same-cycle CPU read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ibf_q <= 1'b0;
        else if (!mode_q)
            ibf_q <= 1'b0;
        else if (fire[0])
            ibf_q <= 1'b1;
        else if (cpu_rd_data)
            ibf_q <= 1'b0;
    end

    // Output full: firmware write sets; it wins over a same-cycle read start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            obf_q <= 1'b0;
        else if (!mode_q)
            obf_q <= 1'b0;
        else if (cpu_wr_data)
            obf_q <= 1'b1;
        else if (starts[1])
            obf_q <= 1'b0;
    end

    // Overflow is sticky; writing zero to its bit clears it, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            input_overflow_flag_q <= 1'b0;
        else if (fire[0] && ibf_q)
            input_overflow_flag_q <= 1'b1;
        else if (wr_acc && hit(paddr, IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS) && !pwdata[B_INPUT_OVERFLOW_FLAG])
            input_overflow_flag_q <= 1'b0;
    end

    // Port interrupt flag: write one to clear, a same-cycle event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pif_q <= 1'b0;
        else if (fire[0] || fire[1])
            pif_q <= 1'b1;
        else if (wr_acc && hit(paddr, IDX_PIR) && pwdata[B_PIF])
            pif_q <= 1'b0;
    end
    assign irq = pif_q & pie_q;

    // Data pin drive: in slave mode only the read strobe decides
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oe_q <= 8'h00;
        else if (mode_q)
            oe_q <= {8{act[1]}};
        else
            oe_q <= ~data_port_direction_q;
    end
    assign data_pin_oe = oe_q;
    assign data_pin_out = dout_q;
    // A clear direction bit drives the pin; firmware sets all three for slave use
    assign ctl_pin_oe = ~dir_q;
    assign ctl_pin_out = cpo_q;

    // Checks kept beside the logic they guard
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr_close;
        ends[0] && mode_q;
    endsequence
    sequence s_rd_close;
        ends[1] && mode_q;
    endsequence

    property p_wr_done;
        s_wr_close |-> ##[1:8] (pif_q && (ibf_q || !mode_q));
    endproperty
    a_wr_done: assert property (p_wr_done)
        else $error("write completion did not raise its flags");

    property p_rd_done;
        s_rd_close |-> ##[1:8] pif_q;
    endproperty
    a_rd_done: assert property (p_rd_done)
        else $error("read completion did not raise the interrupt flag");

    property p_fire_q4;
        (fire[0] || fire[1]) |-> phase_q == PH_Q4 && $past(phase_q, 2) == PH_Q2;
    endproperty
    a_fire_q4: assert property (p_fire_q4)
        else $error("completion not on the Q4 after a Q2");

    property p_ibf_clear;
        mode_q && $past(mode_q) && $fell(ibf_q) |-> $past(cpu_rd_data);
    endproperty
    a_ibf_clear: assert property (p_ibf_clear)
        else $error("input full cleared without a CPU read");

    property p_ovf_set;
        fire[0] && ibf_q |=> input_overflow_flag_q;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow missed on write to unread byte");

    property p_obf_clear;
        starts[1] && !cpu_wr_data |=> !obf_q [*2];
    endproperty
    a_obf_clear: assert property (p_obf_clear)
        else $error("output full not cleared by read start");

    property p_idle_flags;
        !mode_q |=> !ibf_q && !obf_q;
    endproperty
    a_idle_flags: assert property (p_idle_flags)
        else $error("full flags set outside slave mode");

    property p_ovf_sticky;
        input_overflow_flag_q && !(wr_acc && hit(paddr, IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS)) |=> input_overflow_flag_q;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow cleared by hardware");

    property p_irq_gate;
        $rose(pif_q) |-> irq == pie_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt output disagrees with enable");

    property p_oe_read;
        mode_q && $past(mode_q) && data_pin_oe != 8'h00 |-> $past(act[1]);
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("data pins driven without a read strobe");
endmodule

`default_nettype wire

// file: pslp_ext_model.sv
/*
 * Behavioural external processor for the parallel slave port: drives
 * select, write and read strobes (active low) and the data bus.
 * Assumes the bench resolves the data and control wires from all enables.
 */
`default_nettype none

module pslp_ext_model
(
    input wire logic pclk,
    input wire logic [7:0] data_wire,
    output logic [2:0] strobe_n,
    output logic [7:0] data_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: all strobes high, bus released
    initial
    begin
        strobe_n = 3'h7;
        data_drv = 8'h00;
    end

    // One byte out; data held past release as the synchroniser lags
    task automatic ext_write(input logic [7:0] b);
        @(posedge pclk);
        data_drv <= b;
        strobe_n <= 3'h1;
        repeat (6) @(posedge pclk);
        strobe_n <= 3'h7;
        repeat (4) @(posedge pclk);
        // Released bus shows the inverse, not a stale copy
        data_drv <= ~b;
        repeat (12) @(posedge pclk);
    endtask

    // One byte in; sampled late in the strobe so the pins are driven
    task automatic ext_read(output logic [7:0] b);
        @(posedge pclk);
        strobe_n <= 3'h2;
        repeat (6) @(posedge pclk);
        b = data_wire;
        strobe_n <= 3'h7;
        repeat (16) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench for the parallel slave port with an APB master,
 * an integer model of the status flags and the external processor model.
 * Assumes pslp_pkg and pslp_core are compiled first.
 */
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end

module tb_top;
    import pslp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk, presetn, psel, penable, pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, irq;
    logic [7:0] dpo, dpoe, dwire, ext_d, b, r;
    logic [2:0] cpo, cpoe, cwire, ext_s;
    int fail_count, n_checks;
    // Flag model and received bytes
    bit m_ibf, m_obf, m_input_overflow_flag, m_mode;
    logic [7:0] m_out;
    logic [7:0] in_q[$];

    // Wire levels: device drive wins where its enable is high
    assign dwire = (dpoe & dpo) | (~dpoe & ext_d);
    assign cwire = (cpoe & cpo) | (~cpoe & ext_s);

    pslp_core i_pslp_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_pin_in(dwire), .data_pin_out(dpo), .data_pin_oe(dpoe),
        .ctl_pin_in(cwire), .ctl_pin_out(cpo), .ctl_pin_oe(cpoe), .irq(irq));

    pslp_ext_model i_pslp_ext_model (.pclk(pclk), .data_wire(dwire),
        .strobe_n(ext_s), .data_drv(ext_d));

    always #12.5 pclk = ~pclk;

    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One APB transfer; waits on pready under a bound
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            fail_count++;
            tally_and_finish();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        logic e;
        apb(1'b1, idx, d, x, e);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex);
        logic [7:0] x;
        logic e;
        apb(1'b0, idx, 8'h00, x, e);
        `CHK($sformatf("reg %h", idx), ex, x)
    endtask

    // Status register as the model sees it
    function automatic logic [7:0] st();
        return {m_ibf, m_obf, m_input_overflow_flag, m_mode, 1'b0, 3'h7};
    endfunction

    // Runaway guard
    initial
    begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        logic e;
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        void'($urandom(32'h4F28));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and the unmapped hole
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, 8'h07);
        rd_chk(IDX_DATA_PORT_DIRECTION, 8'hFF);
        rd_chk(IDX_PIR, 8'h00);
        rd_chk(IDX_PIE, 8'h00);
        rd_chk(IDX_ADCON, 8'h00);
        rd_chk(IDX_INTERRUPT_CONTROL, 8'h00);
        apb(1'b0, 8'h40, 8'h00, r, e);
        `CHK("slverr", 1'b1, e)
        `CHK("hole", 8'h00, r)
        // Data direction obeyed only outside slave mode
        wr(IDX_DATA_PORT_DIRECTION, 8'h00);
        // Pin enables are registered one edge after the direction write
        repeat (2) @(negedge pclk);
        `CHK("doe", 8'hFF, dpoe)
        wr(IDX_ADCON, ANALOG_PIN_CONFIG_FIELD_DIGITAL);
        wr(IDX_PIE, 8'h80);
        wr(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, 8'h17);
        m_mode = 1;
        repeat (2) @(negedge pclk);
        `CHK("doe", 8'h00, dpoe)
        // Writes from outside, each read back by the CPU
        repeat (3)
        begin
            b = 8'($urandom());
            i_pslp_ext_model.ext_write(b);
            in_q.push_back(b);
            m_ibf = 1;
            rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
            rd_chk(IDX_PIR, 8'h80);
            `CHK("irq", 1'b1, irq)
            rd_chk(IDX_DATA, in_q.pop_back());
            m_ibf = 0;
            rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
            wr(IDX_PIR, 8'h80);
            @(negedge pclk);
            `CHK("irq", 1'b0, irq)
        end
        // Read from outside of a CPU-written byte
        m_out = 8'($urandom());
        wr(IDX_DATA, m_out);
        m_obf = 1;
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
        i_pslp_ext_model.ext_read(r);
        `CHK("ext read", m_out, r)
        m_obf = 0;
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
        rd_chk(IDX_PIR, 8'h80);
        wr(IDX_PIR, 8'h80);
        // Two writes with no CPU read in between
        i_pslp_ext_model.ext_write(8'h3C);
        i_pslp_ext_model.ext_write(8'hC3);
        m_ibf = 1;
        m_input_overflow_flag = 1;
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
        // Leaving slave mode clears the full flags but keeps overflow
        wr(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, 8'h27);
        m_ibf = 0;
        m_mode = 0;
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
        wr(IDX_PIE, 8'h00);
        @(negedge pclk);
        `CHK("irq", 1'b0, irq)
        rd_chk(IDX_PIR, 8'h80);
        wr(IDX_PIR, 8'h80);
        i_pslp_ext_model.ext_write(8'h5A);
        rd_chk(IDX_PIR, 8'h00);
        wr(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, 8'h17);
        m_input_overflow_flag = 0;
        m_mode = 1;
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
        // Analog pin setting keeps the strobes from acting
        wr(IDX_ADCON, 8'h00);
        i_pslp_ext_model.ext_write(8'hA5);
        rd_chk(IDX_PIR, 8'h00);
        rd_chk(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, st());
        // Control pins 0 and 2 as outputs outside slave mode, pin 1 left as input
        wr(IDX_CONTROL_PORT_DIRECTION_AND_SLAVE_STATUS, 8'h02);
        wr(IDX_CPINS, 8'h05);
        @(negedge pclk);
        `CHK("ctl oe", 3'h5, cpoe)
        `CHK("ctl out", 3'h5, cpo)
        tally_and_finish();
    end
endmodule

`default_nettype wire
